// >>> dual_timer.v
// Purpose: two 8/16-bit timers with clock source selection, AHB-Lite registers
// Assumes: single hclk domain, word-only AHB transfers, pins asynchronous
// Notes: the clock output pin is hclk gated by an enable caught on the falling edge
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "dual_timer_defines.vh"

// Notes on behaviour
// - timer zero low byte readable, writable, resets zero
// - timer zero high byte readable, writable, resets zero
// - timer one low byte readable, writable, resets zero
// - timer one high byte readable, writable, resets zero
// - timer zero clock: divide by twelve or direct
// - timer one clock: divide by twelve or direct
// - pwm clock: system clock or timer one overflow
// - clock output enable drives system clock out
// - clock control register resets to all zeros
// - timer counts only while run bit set
// - overflow sets flag, isr clears, software writes
// - mode field: 13-bit, 16-bit, reload, split/halt
// - counter select uses pin falls; gate needs irq high
module dual_timer (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire timer_zero_count_pin,
    input wire timer_one_count_pin,
    input wire external_irq_zero_input,
    input wire external_irq_one_input,
    input wire timer_zero_isr_ack,
    input wire timer_one_isr_ack,
    output reg timer_zero_overflow_flag,
    output reg timer_one_overflow_flag,
    output reg pwm_clock_tick,
    output wire clock_output_pin,
    output reg irq
);

    // ****************************************
    // counting step for modes 0 to 2
    // ****************************************
    // returns {overflow, high byte, low byte}; mode 3 is handled by the caller
    function [16:0] count_step;
        input [1:0] mode;
        input [15:0] cnt;
        reg [13:0] c13;
        begin
            c13 = {1'b0, cnt[15:8], cnt[4:0]} + 14'h0001;
            case (mode)
                2'b00: begin
                    count_step = {c13[13], c13[12:5], cnt[7:5], c13[4:0]};
                end
                2'b01: begin
                    count_step = {1'b0, cnt} + 17'h00001;
                end
                2'b10: begin
                    if (cnt[7:0] == 8'hff) begin
                        count_step = {1'b1, cnt[15:8], cnt[15:8]};
                    end else begin
                        count_step = {1'b0, cnt[15:8], cnt[7:0] + 8'h01};
                    end
                end
                default: begin
                    count_step = {1'b0, cnt};
                end
            endcase
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg [15:0] cnt0_ff;
    reg [15:0] cnt1_ff;
    reg [7:0] clksrc_ff;
    reg [7:0] control_ff;
    reg [7:0] tmod_ff;
    reg [1:0] status_ff;
    reg [1:0] mask_ff;
    reg [3:0] presc_ff;
    reg [3:0] s1_ff;
    reg [3:0] s2_ff;
    reg [3:0] s3_ff;
    reg dp_wr_ff;
    reg [9:0] dp_idx_ff;
    reg clko_en_ff;

    reg [15:0] nxt_cnt0;
    reg [15:0] nxt_cnt1;
    reg [7:0] nxt_clksrc;
    reg [7:0] nxt_control;
    reg [7:0] nxt_tmod;
    reg [1:0] nxt_status;
    reg [1:0] nxt_mask;
    reg [3:0] nxt_presc;
    reg [31:0] nxt_rdata;
    reg ovf0;
    reg ovf1;
    reg ovf_hi0;
    wire [7:0] wdat;

    wire tick12;
    wire [1:0] tick;
    wire [1:0] run;
    wire [1:0] clk_mode;
    wire [3:0] pin_fall;
    wire addr_phase;
    wire split0;
    wire hi0_tick;

    assign wdat = hwdata[7:0];

    // ****************************************
    // pin synchronisers
    // ****************************************
    // order: {irq one, irq zero, count one, count zero}; s3 only feeds edge detection
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_ff <= 4'h0;
            s2_ff <= 4'h0;
            s3_ff <= 4'h0;
        end else begin
            s1_ff <= {external_irq_one_input, external_irq_zero_input,
                      timer_one_count_pin, timer_zero_count_pin};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    assign pin_fall = s3_ff & ~s2_ff;

    // ****************************************
    // divide-by-twelve prescaler
    // ****************************************
    // free running so both timers share one phase of the slow tick
    always @* begin
        if (presc_ff == `PRESCALE_LAST) begin
            nxt_presc = 4'h0;
        end else begin
            nxt_presc = presc_ff + 4'h1;
        end
    end

    assign tick12 = (presc_ff == `PRESCALE_LAST);
    assign run = {control_ff[`RUN_ONE_BIT], control_ff[`RUN_ZERO_BIT]};
    assign clk_mode = {clksrc_ff[`TIMER_ONE_CLOCK_MODE_BIT], clksrc_ff[`TIMER_ZERO_CLOCK_MODE_BIT]};

    // ****************************************
    // per-timer tick selection
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_tick
            wire cnt_sel;
            wire gate;
            wire src;
            wire allow;
            assign cnt_sel = tmod_ff[4 * gi + 2];
            assign gate = tmod_ff[4 * gi + 3];
            // counter select takes pin falls, else direct or divided clock
            assign src = cnt_sel ? pin_fall[gi] : (clk_mode[gi] | tick12);
            assign allow = run[gi] & (~gate | s2_ff[2 + gi]);
            // timer one stands still in mode 3
            if (gi == 1) begin : g_halt
                assign tick[gi] = src & allow & (tmod_ff[5:4] != 2'b11);
            end else begin : g_run
                assign tick[gi] = src & allow;
            end
        end
    endgenerate

    // in split mode the high byte of timer zero borrows timer one's run bit
    assign split0 = (tmod_ff[1:0] == 2'b11);
    assign hi0_tick = split0 & run[1] & (clk_mode[0] | tick12);

    // ****************************************
    // bus address phase
    // ****************************************
    assign addr_phase = hsel & htrans[1] & hready;

    // ****************************************
    // next count values, software writes override
    // ****************************************
    always @* begin
        nxt_cnt0 = cnt0_ff;
        nxt_cnt1 = cnt1_ff;
        ovf0 = 1'b0;
        ovf1 = 1'b0;
        ovf_hi0 = 1'b0;
        if (tick[0]) begin
            if (split0) begin
                {ovf0, nxt_cnt0[7:0]} = {1'b0, cnt0_ff[7:0]} + 9'h001;
            end else begin
                {ovf0, nxt_cnt0} = count_step(tmod_ff[1:0], cnt0_ff);
            end
        end
        if (hi0_tick) begin
            {ovf_hi0, nxt_cnt0[15:8]} = {1'b0, cnt0_ff[15:8]} + 9'h001;
        end
        if (tick[1]) begin
            {ovf1, nxt_cnt1} = count_step(tmod_ff[5:4], cnt1_ff);
        end
        // a write lands this cycle and counting resumes from it
        if (dp_wr_ff) begin
            if (dp_idx_ff == {2'b00, `TIMER_ZERO_COUNT_LOW_IDX}) begin
                nxt_cnt0[7:0] = wdat;
            end
            if (dp_idx_ff == {2'b00, `TIMER_ZERO_COUNT_HIGH_IDX}) begin
                nxt_cnt0[15:8] = wdat;
            end
            if (dp_idx_ff == {2'b00, `TIMER_ONE_COUNT_LOW_IDX}) begin
                nxt_cnt1[7:0] = wdat;
            end
            if (dp_idx_ff == {2'b00, `TIMER_ONE_COUNT_HIGH_IDX}) begin
                nxt_cnt1[15:8] = wdat;
            end
        end
    end

    // ****************************************
    // control, flags and interrupt status
    // ****************************************
    // hardware set beats both the isr ack and a software clear in the same cycle
    always @* begin
        nxt_clksrc = clksrc_ff;
        nxt_tmod = tmod_ff;
        nxt_control = control_ff;
        nxt_mask = mask_ff;
        nxt_status = status_ff;
        if (timer_zero_isr_ack) begin
            nxt_control[`FLAG_ZERO_BIT] = 1'b0;
        end
        if (timer_one_isr_ack) begin
            nxt_control[`FLAG_ONE_BIT] = 1'b0;
        end
        if (dp_wr_ff) begin
            case (dp_idx_ff)
                {2'b00, `TIMER_CLOCK_SOURCE_CONTROL_IDX}: begin
                    nxt_clksrc = wdat & `CLOCK_SOURCE_WRITABLE_MASK;
                end
                {2'b00, `TIMER_MODE_CONTROL_IDX}: begin
                    nxt_tmod = wdat;
                end
                {2'b00, `TIMER_RUN_FLAG_CONTROL_IDX}: begin
                    nxt_control = wdat & `CONTROL_WRITABLE_MASK;
                end
                {2'b00, `TIMER_IRQ_MASK_IDX}: begin
                    nxt_mask = wdat[1:0];
                end
                {2'b00, `TIMER_IRQ_STATUS_IDX}: begin
                    nxt_status = status_ff & ~wdat[1:0];
                end
                default: begin
                    nxt_mask = mask_ff;
                end
            endcase
        end
        if (ovf0) begin
            nxt_control[`FLAG_ZERO_BIT] = 1'b1;
            nxt_status[0] = 1'b1;
        end
        // split mode: the high byte of timer zero owns timer one's flag
        if (split0 ? ovf_hi0 : ovf1) begin
            nxt_control[`FLAG_ONE_BIT] = 1'b1;
            nxt_status[1] = 1'b1;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    // built from next values so a read right after a write sees the new byte
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (haddr[11:2])
            {2'b00, `TIMER_ZERO_COUNT_LOW_IDX}: nxt_rdata[7:0] = nxt_cnt0[7:0];
            {2'b00, `TIMER_ZERO_COUNT_HIGH_IDX}: nxt_rdata[7:0] = nxt_cnt0[15:8];
            {2'b00, `TIMER_ONE_COUNT_LOW_IDX}: nxt_rdata[7:0] = nxt_cnt1[7:0];
            {2'b00, `TIMER_ONE_COUNT_HIGH_IDX}: nxt_rdata[7:0] = nxt_cnt1[15:8];
            {2'b00, `TIMER_CLOCK_SOURCE_CONTROL_IDX}: nxt_rdata[7:0] = nxt_clksrc;
            {2'b00, `TIMER_MODE_CONTROL_IDX}: nxt_rdata[7:0] = nxt_tmod;
            {2'b00, `TIMER_RUN_FLAG_CONTROL_IDX}: nxt_rdata[7:0] = nxt_control;
            {2'b00, `TIMER_IRQ_STATUS_IDX}: nxt_rdata[1:0] = nxt_status;
            {2'b00, `TIMER_IRQ_MASK_IDX}: nxt_rdata[1:0] = nxt_mask;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt0_ff <= {`COUNT_RESET, `COUNT_RESET};
            cnt1_ff <= {`COUNT_RESET, `COUNT_RESET};
            clksrc_ff <= `CLOCK_SOURCE_RESET;
            tmod_ff <= `CONTROL_RESET;
            control_ff <= `CONTROL_RESET;
            status_ff <= 2'b00;
            mask_ff <= 2'b00;
            presc_ff <= 4'h0;
            dp_wr_ff <= 1'b0;
            dp_idx_ff <= 10'h000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            timer_zero_overflow_flag <= 1'b0;
            timer_one_overflow_flag <= 1'b0;
            pwm_clock_tick <= 1'b0;
            irq <= 1'b0;
        end else begin
            cnt0_ff <= nxt_cnt0;
            cnt1_ff <= nxt_cnt1;
            clksrc_ff <= nxt_clksrc;
            tmod_ff <= nxt_tmod;
            control_ff <= nxt_control;
            status_ff <= nxt_status;
            mask_ff <= nxt_mask;
            presc_ff <= nxt_presc;
            dp_wr_ff <= addr_phase & hwrite;
            dp_idx_ff <= haddr[11:2];
            if (addr_phase & ~hwrite) begin
                hrdata <= nxt_rdata;
            end
            // zero wait states, always okay
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            timer_zero_overflow_flag <= nxt_control[`FLAG_ZERO_BIT];
            timer_one_overflow_flag <= nxt_control[`FLAG_ONE_BIT];
            // one pulse per pwm clock: every cycle, or per timer one overflow
            pwm_clock_tick <= nxt_clksrc[`PWM_CLOCK_SELECT_BIT] ? ovf1 : 1'b1;
            irq <= |(nxt_status & nxt_mask);
        end
    end

    // ****************************************
    // clock output gate
    // ****************************************
    // enable caught while hclk is low so the gated clock never shows a runt pulse
    always @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clko_en_ff <= 1'b0;
        end else begin
            clko_en_ff <= clksrc_ff[`CLOCK_OUTPUT_ENABLE_BIT];
        end
    end

    assign clock_output_pin = hclk & clko_en_ff;

endmodule // dual_timer
`default_nettype wire

// >>> dual_timer_assertions.sv
// Purpose: port level checks for the dual timer block
// Assumes: zero wait state bus, hready fed back from hreadyout
// Notes: bus writes are shadowed here to know run, mask and clock bits
`timescale 1ns/1ps
`default_nettype none
module dual_timer_assertions (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire timer_zero_isr_ack,
    input wire timer_zero_overflow_flag,
    input wire timer_one_overflow_flag,
    input wire pwm_clock_tick,
    input wire irq
);
// ****************************************
// bus shadow
// ****************************************
reg dp_ff;
reg wr_ff;
reg [11:0] adr_ff;
reg run0_ff;
reg run1_ff;
reg [7:0] ck_ff;
reg [1:0] mask_ff;
wire wr_done = dp_ff & wr_ff;
wire ctl_wr = wr_done & (adr_ff == 12'h220);
wire rd_now = dp_ff & ~wr_ff;
wire known = (adr_ff >= 12'h220 && adr_ff <= 12'h238) || adr_ff == 12'h280 || adr_ff == 12'h284;
// shadows land on the data phase edge, the same edge the design stores the write
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        dp_ff <= 1'b0;
        wr_ff <= 1'b0;
        adr_ff <= 12'h000;
        run0_ff <= 1'b0;
        run1_ff <= 1'b0;
        ck_ff <= 8'h00;
        mask_ff <= 2'b00;
    end else begin
        dp_ff <= hsel & htrans[1] & hready;
        wr_ff <= hwrite;
        adr_ff <= haddr;
        if (ctl_wr) begin
            run0_ff <= hwdata[4];
            run1_ff <= hwdata[6];
        end
        if (wr_done && adr_ff == 12'h238) begin
            ck_ff <= hwdata[7:0] & 8'h5a;
        end
        if (wr_done && adr_ff == 12'h284) begin
            mask_ff <= hwdata[1:0];
        end
    end
end
// ****************************************
// properties
// ****************************************
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
sequence s_pwm_on_sys;
    !ck_ff[6] ##1 !ck_ff[6];
endsequence
sequence s_zero_idle_ack;
    !run0_ff && timer_zero_isr_ack && !ctl_wr;
endsequence
a_ready_zero_wait: assert property (hreadyout) else $error("wait state inserted");
a_resp_always_okay: assert property (!hresp) else $error("error response seen");
a_unmapped_reads_zero: assert property (rd_now && adr_ff[1:0] == 2'b00 && !known |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
a_clock_ctl_readback: assert property (rd_now && adr_ff == 12'h238 |-> hrdata == {24'h0, ck_ff})
    else $error("clock control readback wrong");
a_pwm_sys_tick: assert property (s_pwm_on_sys |-> pwm_clock_tick)
    else $error("pwm tick missing on system clock");
a_pwm_from_overflow: assert property (ck_ff[6] && $past(ck_ff[6]) && pwm_clock_tick |-> timer_one_overflow_flag)
    else $error("pwm tick without timer one overflow");
a_isr_ack_clears: assert property (s_zero_idle_ack |=> !timer_zero_overflow_flag)
    else $error("isr ack left flag set");
a_stopped_no_flag: assert property (!run1_ff && !ctl_wr |=> !$rose(timer_one_overflow_flag))
    else $error("stopped timer raised its flag");
a_irq_masked_low: assert property (mask_ff == 2'b00 |-> !irq)
    else $error("irq high with all sources masked");
endmodule // dual_timer_assertions
bind dual_timer dual_timer_assertions chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_zero_isr_ack(timer_zero_isr_ack),
    .timer_zero_overflow_flag(timer_zero_overflow_flag),
    .timer_one_overflow_flag(timer_one_overflow_flag),
    .pwm_clock_tick(pwm_clock_tick), .irq(irq)
);
`default_nettype wire

// >>> dual_timer_defines.vh
// Purpose: constants for the dual timer count and clock select block
// Assumes: register index times four gives the AHB byte address
// Notes: definitions only
`ifndef DUAL_TIMER_DEFINES_VH
`define DUAL_TIMER_DEFINES_VH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define TIMER_RUN_FLAG_CONTROL_IDX 8'h88
`define TIMER_MODE_CONTROL_IDX 8'h89
`define TIMER_ZERO_COUNT_LOW_IDX 8'h8a
`define TIMER_ONE_COUNT_LOW_IDX 8'h8b
`define TIMER_ZERO_COUNT_HIGH_IDX 8'h8c
`define TIMER_ONE_COUNT_HIGH_IDX 8'h8d
`define TIMER_CLOCK_SOURCE_CONTROL_IDX 8'h8e
`define TIMER_IRQ_STATUS_IDX 8'ha0
`define TIMER_IRQ_MASK_IDX 8'ha1

// ****************************************
// reset values
// ****************************************
`define COUNT_RESET 8'h00
`define CLOCK_SOURCE_RESET 8'h00
`define CONTROL_RESET 8'h00

// ****************************************
// field positions
// ****************************************
`define RUN_ZERO_BIT 4
`define FLAG_ZERO_BIT 5
`define RUN_ONE_BIT 6
`define FLAG_ONE_BIT 7
`define PWM_CLOCK_SELECT_BIT 6
`define TIMER_ONE_CLOCK_MODE_BIT 4
`define TIMER_ZERO_CLOCK_MODE_BIT 3
`define CLOCK_OUTPUT_ENABLE_BIT 1
`define CLOCK_SOURCE_WRITABLE_MASK 8'h5a
`define CONTROL_WRITABLE_MASK 8'hf0

// ****************************************
// timing
// ****************************************
`define PRESCALE_DIVIDE 12
`define PRESCALE_LAST 4'hb

`endif

// >>> tb_dual_timer_count_clock_select.sv
// Purpose: self-checking bench for the dual timer block
// Assumes: zero wait state AHB-Lite slave, byte address is index times four
// Notes: prescaler phase is free running, so divided counts are checked as ranges
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_dual_timer_count_clock_select;
logic hclk, hresetn, hsel, hwrite, pin0, pin1, irq0, irq1, ack0, ack1;
logic [11:0] haddr;
logic [1:0] htrans;
logic [2:0] hsize;
logic [31:0] hwdata, rd, c;
wire [31:0] hrdata;
wire hreadyout, hresp, flag0, flag1, pwm_tick, clk_out, irq;
int comparisons, fails, i, t, m;
localparam logic [11:0] A_CTL = 12'h220, A_MODE = 12'h224, A_T0L = 12'h228, A_T1L = 12'h22c;
localparam logic [11:0] A_T0H = 12'h230, A_T1H = 12'h234, A_CK = 12'h238, A_ST = 12'h280;
dual_timer uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_zero_count_pin(pin0),
    .timer_one_count_pin(pin1), .external_irq_zero_input(irq0),
    .external_irq_one_input(irq1), .timer_zero_isr_ack(ack0), .timer_one_isr_ack(ack1),
    .timer_zero_overflow_flag(flag0), .timer_one_overflow_flag(flag1),
    .pwm_clock_tick(pwm_tick), .clock_output_pin(clk_out), .irq(irq)
);
// ****************************************
// bus and helper tasks
// ****************************************
// one single transfer; read data is taken at the edge that ends the data phase
// hsel stays high and idle htrans marks the gaps, so back to back calls never drive it low
task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    begin
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    end
endtask
// falling edges on both count pins, held long enough for the synchroniser
task automatic falls(input int n);
    begin
        repeat (n) begin
            {pin0, pin1} <= 2'b00;
            repeat (3) @(posedge hclk);
            {pin0, pin1} <= 2'b11;
            repeat (3) @(posedge hclk);
        end
    end
endtask
task end_sim;
    begin
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    end
endtask
// clock, 50 ns period
initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
end
// watchdog: the sequence needs well under 3000 cycles
initial begin
    #(50 * 20000);
    fails++;
    end_sim();
end
// ****************************************
// main sequence
// ****************************************
initial begin
    {hresetn, hsel, hwrite, pin0, pin1, irq0, irq1, ack0, ack1} = 9'b000110000;
    haddr = 12'h000;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, then each count byte written and read back
    for (i = 0; i < 5; i++) begin
        xfer(1'b0, A_T0L + 12'(4 * i), 8'h00);
        `CHK(rd, 32'h0)
    end
    for (i = 0; i < 4; i++) begin
        xfer(1'b1, A_T0L + 12'(4 * i), 8'h3c + 8'(i));
        xfer(1'b0, A_T0L + 12'(4 * i), 8'h00);
        `CHK(rd, 32'h3c + 32'(i))
    end
    xfer(1'b1, 12'h2fc, 8'hff);
    xfer(1'b0, 12'h2fc, 8'h00);
    `CHK(rd, 32'h0)
    // divide by twelve against direct clock, both timers in 16-bit mode
    for (t = 0; t < 2; t++) for (m = 0; m < 2; m++) begin
        xfer(1'b1, A_MODE, 8'h11);
        xfer(1'b1, t ? A_T1L : A_T0L, 8'h00);
        xfer(1'b1, t ? A_T1H : A_T0H, 8'h00);
        xfer(1'b1, A_CK, m ? (t ? 8'h10 : 8'h08) : 8'h00);
        xfer(1'b1, A_CTL, t ? 8'h40 : 8'h10);
        repeat (118) @(posedge hclk);
        xfer(1'b1, A_CTL, 8'h00);
        xfer(1'b0, t ? A_T1L : A_T0L, 8'h00);
        c = rd;
        `CHK(c >= (m ? 119 : 9) && c <= (m ? 120 : 10), 1'b1)
        repeat (24) @(posedge hclk);
        xfer(1'b0, t ? A_T1L : A_T0L, 8'h00);
        `CHK(rd, c)
    end
    // timer one overflow drives flag, irq and the pwm clock
    xfer(1'b1, A_CK, 8'h50);
    xfer(1'b1, A_T1H, 8'hff);
    xfer(1'b1, A_T1L, 8'hf8);
    xfer(1'b1, 12'h284, 8'h02);
    xfer(1'b1, A_CTL, 8'h40);
    repeat (12) @(posedge hclk);
    `CHK({flag1, irq}, 2'b11)
    xfer(1'b1, A_CTL, 8'h80);
    xfer(1'b0, A_T1H, 8'h00);
    `CHK(rd, 32'h0)
    ack1 <= 1'b1;
    @(posedge hclk);
    ack1 <= 1'b0;
    @(posedge hclk);
    `CHK({flag1, irq}, 2'b01)
    xfer(1'b0, A_ST, 8'h00);
    `CHK(rd, 32'h2)
    xfer(1'b1, A_ST, 8'h02);
    @(posedge hclk);
    `CHK(irq, 1'b0)
    xfer(1'b1, A_CTL, 8'h20);
    @(posedge hclk);
    `CHK(flag0, 1'b1)
    // isr ack on a stopped timer clears the software-set flag
    ack0 <= 1'b1;
    @(posedge hclk);
    ack0 <= 1'b0;
    @(posedge hclk);
    `CHK(flag0, 1'b0)
    // 13-bit wrap keeps low bits 7:5, mode 2 reloads low from high
    for (m = 0; m < 2; m++) begin
        xfer(1'b1, A_CTL, 8'h00);
        xfer(1'b1, A_MODE, m ? 8'h02 : 8'h00);
        xfer(1'b1, A_CK, 8'h08);
        xfer(1'b1, A_T0H, m ? 8'hf0 : 8'hff);
        xfer(1'b1, A_T0L, m ? 8'hfe : 8'hff);
        xfer(1'b1, A_CTL, 8'h10);
        repeat (3) @(posedge hclk);
        `CHK(flag0, 1'b1)
        xfer(1'b1, A_CTL, 8'h00);
        xfer(1'b0, A_T0H, 8'h00);
        `CHK(rd, m ? 32'hf0 : 32'h0)
        xfer(1'b0, A_T0L, 8'h00);
        `CHK(rd[7:5], 3'b111)
    end
    // pin falls counted on both timers; each gate holds its count while its input is low
    xfer(1'b1, A_MODE, 8'h55);
    xfer(1'b1, A_T0L, 8'h00);
    xfer(1'b1, A_T1L, 8'h00);
    xfer(1'b1, A_CTL, 8'h50);
    falls(3);
    xfer(1'b1, A_MODE, 8'hdd);
    falls(2);
    irq0 <= 1'b1;
    falls(2);
    xfer(1'b1, A_CTL, 8'h00);
    xfer(1'b0, A_T0L, 8'h00);
    `CHK(rd, 32'h5)
    xfer(1'b0, A_T1L, 8'h00);
    `CHK(rd, 32'h3)
    // split timer zero: high byte runs on timer one's run bit and flag; timer one halts
    xfer(1'b1, A_MODE, 8'h33);
    xfer(1'b1, A_T0L, 8'hfe);
    xfer(1'b1, A_T0H, 8'hff);
    xfer(1'b1, A_T1L, 8'h00);
    xfer(1'b1, A_CTL, 8'h50);
    repeat (3) @(posedge hclk);
    `CHK({flag1, flag0}, 2'b11)
    xfer(1'b1, A_CTL, 8'h00);
    xfer(1'b0, A_T1L, 8'h00);
    `CHK(rd, 32'h0)
    xfer(1'b0, A_T0H, 8'h00);
    `CHK(rd, 32'h4)
    // clock output follows hclk only while enabled
    xfer(1'b1, A_CK, 8'h02);
    repeat (2) @(posedge hclk);
    #10;
    `CHK(clk_out, 1'b1)
    @(posedge hclk);
    xfer(1'b1, A_CK, 8'h00);
    repeat (2) @(posedge hclk);
    #10;
    `CHK(clk_out, 1'b0)
    end_sim();
end
endmodule // tb_dual_timer_count_clock_select
`default_nettype wire
